/* File: tc_timer_top.sv */
// Dual 16-bit timer/counter with control, mode and count registers.
// Assumes AXI4-Lite register access, synchronous pins and a vector
// acknowledge pulse from the interrupt controller for each flag.
//
// The AXI4-Lite interface to the registers was left to the implementer.

`timescale 1ns/1ps
`default_nettype none

module tc_timer_top
    import tc_pkg::*;
#(
    parameter int unsigned ADDR_W = 12,
    parameter int unsigned MACHINE_DIV = MACHINE_CYCLE_CLKS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic count_pin_0,
    input wire logic count_pin_1,
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic vec_ack_timer0,
    input wire logic vec_ack_timer1,
    input wire logic vec_ack_ext0,
    input wire logic vec_ack_ext1,
    output logic timer0_overflow_flag,
    output logic timer1_overflow_flag,
    output logic ext_irq0_flag,
    output logic ext_irq1_flag
);

    if (ADDR_W < 10 || ADDR_W > 32) begin : g_chk_addr
        $error("ADDR_W must cover the register map, 10 to 32 bits");
    end
    if (MACHINE_DIV < 2 || MACHINE_DIV > 256) begin : g_chk_div
        $error("MACHINE_DIV must be 2 to 256");
    end

    localparam int IW = ADDR_W - 2;

    // Registers
    logic [7:0] ctrl_reg;
    logic [7:0] mode_reg;
    logic [7:0] aux_reg;
    logic [7:0] tl0_reg;
    logic [7:0] th0_reg;
    logic [7:0] tl1_reg;
    logic [7:0] th1_reg;
    logic [7:0] pre_reg;
    logic [1:0] xpin_prev_reg;

    // Bus slave state
    logic aw_got_reg;
    logic w_got_reg;
    logic [IW-1:0] aw_idx_reg;
    logic [7:0] wbyte_reg;
    logic wlane_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    logic machine_tick;
    logic [1:0] rate_tick;
    logic [1:0] run;
    logic [1:0] gate;
    logic [1:0] count_ext;
    logic [1:0] count_en;
    logic [1:0] inc;
    logic [1:0] cpin;
    logic [1:0] xpin;
    logic [1:0] fast;
    tc_mode_t mode0;
    tc_mode_t mode1;
    logic split0;
    logic th0_split_inc;

    logic wr_go;
    logic wr_hit;
    logic we_ctrl;
    logic we_mode;
    logic we_aux;
    logic we_tl0;
    logic we_th0;
    logic we_tl1;
    logic we_th1;

    logic [7:0] tl0_next;
    logic [7:0] th0_next;
    logic [7:0] tl1_next;
    logic [7:0] th1_next;
    logic [7:0] ctrl_next;
    logic [7:0] ctrl_base;
    logic ovf0;
    logic ovf1;
    logic ovf_th0;
    logic [16:0] step0;
    logic [16:0] step1;
    logic [7:0] rd_byte;
    logic rd_hit;

    // One step of modes 0 to 2: {overflow, high, low}
    function automatic logic [16:0] tc_step(input tc_mode_t mode, input logic [7:0] lo, input logic [7:0] hi);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0] c8;
        c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        c16 = {1'b0, hi, lo} + 17'h0_0001;
        c8 = {1'b0, lo} + 9'h001;
        case (mode)
            TC_MODE_13: begin
                // Upper three low-byte bits are left alone
                tc_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
            end
            TC_MODE_16: begin
                tc_step = c16;
            end
            TC_MODE_AUTO8: begin
                tc_step = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]};
            end
            default: begin
                tc_step = {1'b0, hi, lo};
            end
        endcase
    endfunction

    // Machine-cycle prescaler
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pre_reg <= 8'h00;
        end else if (ce) begin
            pre_reg <= machine_tick ? 8'h00 : pre_reg + 8'h01;
        end
    end

    always_comb begin
        machine_tick = (pre_reg == 8'(MACHINE_DIV - 1));
        cpin = {count_pin_1, count_pin_0};
        xpin = {ext_irq1_pin, ext_irq0_pin};
        fast = {aux_reg[AUX_FAST1], aux_reg[AUX_FAST0]};
        run = {ctrl_reg[CTRL_TR1], ctrl_reg[CTRL_TR0]};
        mode0 = tc_mode_t'(mode_reg[NIB_MODE_LSB +: 2]);
        mode1 = tc_mode_t'(mode_reg[MODE_NIB_W + NIB_MODE_LSB +: 2]);
        split0 = (mode0 == TC_MODE_SPLIT);
        // High byte of split Timer 0: internal rate only, Timer 1 run, no gate
        th0_split_inc = rate_tick[0] & run[1];
    end

    for (genvar i = 0; i < 2; i++) begin : g_tmr
        always_comb begin
            rate_tick[i] = fast[i] | machine_tick;
            gate[i] = mode_reg[MODE_NIB_W * i + NIB_GATE];
            count_ext[i] = mode_reg[MODE_NIB_W * i + NIB_SELECT];
            count_en[i] = run[i] & (~gate[i] | xpin[i]);
        end

        tc_event_unit u_event (
            .sys_clk(sys_clk),
            .rst(rst),
            .ce(ce),
            .rate_tick(rate_tick[i]),
            .count_ext(count_ext[i]),
            .enable(count_en[i]),
            .count_pin(cpin[i]),
            .inc(inc[i])
        );
    end

    // Count next values
    always_comb begin
        step0 = tc_step(mode0, tl0_reg, th0_reg);
        step1 = tc_step(mode1, tl1_reg, th1_reg);
        tl0_next = tl0_reg;
        th0_next = th0_reg;
        tl1_next = tl1_reg;
        th1_next = th1_reg;
        ovf0 = 1'b0;
        ovf1 = 1'b0;
        ovf_th0 = 1'b0;
        if (split0) begin
            if (inc[0]) begin
                tl0_next = tl0_reg + 8'h01;
                ovf0 = &tl0_reg;
            end
            if (th0_split_inc) begin
                th0_next = th0_reg + 8'h01;
                ovf_th0 = &th0_reg;
            end
        end else if (inc[0]) begin
            {ovf0, th0_next, tl0_next} = step0;
        end
        // Mode 3 on Timer 1 holds the count
        if (inc[1] && mode1 != TC_MODE_SPLIT) begin
            {ovf1, th1_next, tl1_next} = step1;
        end
    end

    // Software write wins over a count step in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tl0_reg <= REG_RESET;
            th0_reg <= REG_RESET;
            tl1_reg <= REG_RESET;
            th1_reg <= REG_RESET;
        end else if (ce) begin
            tl0_reg <= we_tl0 ? wbyte_reg : tl0_next;
            th0_reg <= we_th0 ? wbyte_reg : th0_next;
            tl1_reg <= we_tl1 ? wbyte_reg : tl1_next;
            th1_reg <= we_th1 ? wbyte_reg : th1_next;
        end
    end

    // Flags: hardware set beats both software clear and vector clear
    always_comb begin
        ctrl_base = we_ctrl ? wbyte_reg : ctrl_reg;
        ctrl_next = ctrl_base;
        // Split Timer 0 owns the Timer 1 flag; Timer 1 overflow is then unflagged
        ctrl_next[CTRL_TF1] = ovf_th0 | (ovf1 & ~split0) | (ctrl_base[CTRL_TF1] & ~vec_ack_timer1);
        ctrl_next[CTRL_TF0] = ovf0 | (ctrl_base[CTRL_TF0] & ~vec_ack_timer0);
        if (ctrl_reg[CTRL_XT1]) begin
            ctrl_next[CTRL_XF1] = (xpin_prev_reg[1] & ~xpin[1]) | (ctrl_base[CTRL_XF1] & ~vec_ack_ext1);
        end else begin
            ctrl_next[CTRL_XF1] = ~xpin[1];
        end
        if (ctrl_reg[CTRL_XT0]) begin
            ctrl_next[CTRL_XF0] = (xpin_prev_reg[0] & ~xpin[0]) | (ctrl_base[CTRL_XF0] & ~vec_ack_ext0);
        end else begin
            ctrl_next[CTRL_XF0] = ~xpin[0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= REG_RESET;
        end else if (ce) begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Pins idle high, so reset high avoids a false falling edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            xpin_prev_reg <= 2'h3;
        end else if (ce) begin
            xpin_prev_reg <= xpin;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mode_reg <= REG_RESET;
            aux_reg <= REG_RESET;
        end else if (ce) begin
            if (we_mode) begin
                mode_reg <= wbyte_reg;
            end
            if (we_aux) begin
                aux_reg <= wbyte_reg & AUX_MASK;
            end
        end
    end

    // Write decode
    always_comb begin
        wr_go = aw_got_reg & w_got_reg & ~bvalid_reg;
        wr_hit = 1'b1;
        we_ctrl = 1'b0;
        we_mode = 1'b0;
        we_aux = 1'b0;
        we_tl0 = 1'b0;
        we_th0 = 1'b0;
        we_tl1 = 1'b0;
        we_th1 = 1'b0;
        case (aw_idx_reg)
            IW'(IDX_TIMER_CTRL_FLAGS): we_ctrl = wr_go & wlane_reg;
            IW'(IDX_TIMER_MODE_SELECT): we_mode = wr_go & wlane_reg;
            IW'(IDX_AUX_CONTROL_2): we_aux = wr_go & wlane_reg;
            IW'(IDX_TIMER0_COUNT_LOW): we_tl0 = wr_go & wlane_reg;
            IW'(IDX_TIMER0_COUNT_HIGH): we_th0 = wr_go & wlane_reg;
            IW'(IDX_TIMER1_COUNT_LOW): we_tl1 = wr_go & wlane_reg;
            IW'(IDX_TIMER1_COUNT_HIGH): we_th1 = wr_go & wlane_reg;
            default: wr_hit = 1'b0;
        endcase
    end

    // Read decode
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr[ADDR_W-1:2])
            IW'(IDX_TIMER_CTRL_FLAGS): rd_byte = ctrl_reg;
            IW'(IDX_TIMER_MODE_SELECT): rd_byte = mode_reg;
            IW'(IDX_AUX_CONTROL_2): rd_byte = aux_reg;
            IW'(IDX_TIMER0_COUNT_LOW): rd_byte = tl0_reg;
            IW'(IDX_TIMER0_COUNT_HIGH): rd_byte = th0_reg;
            IW'(IDX_TIMER1_COUNT_LOW): rd_byte = tl1_reg;
            IW'(IDX_TIMER1_COUNT_HIGH): rd_byte = th1_reg;
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Write channel: address and data taken in either order, one at a time
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_idx_reg <= '0;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= AXI_RESP_OKAY;
        end else if (ce) begin
            if (awready_reg && s_axi_awvalid) begin
                aw_got_reg <= 1'b1;
                aw_idx_reg <= s_axi_awaddr[ADDR_W-1:2];
                awready_reg <= 1'b0;
            end
            if (wready_reg && s_axi_wvalid) begin
                w_got_reg <= 1'b1;
                wbyte_reg <= s_axi_wdata[7:0];
                wlane_reg <= s_axi_wstrb[0];
                wready_reg <= 1'b0;
            end
            if (wr_go) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
            end
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // Read channel: data registered on the same edge the address is taken
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= AXI_RESP_OKAY;
        end else if (ce) begin
            if (arready_reg && s_axi_arvalid) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= {24'h00_0000, rd_byte};
                rresp_reg <= rd_hit ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    always_comb begin
        s_axi_awready = awready_reg;
        s_axi_wready = wready_reg;
        s_axi_bvalid = bvalid_reg;
        s_axi_bresp = bresp_reg;
        s_axi_arready = arready_reg;
        s_axi_rvalid = rvalid_reg;
        s_axi_rdata = rdata_reg;
        s_axi_rresp = rresp_reg;
        timer0_overflow_flag = ctrl_reg[CTRL_TF0];
        timer1_overflow_flag = ctrl_reg[CTRL_TF1];
        ext_irq0_flag = ctrl_reg[CTRL_XF0];
        ext_irq1_flag = ctrl_reg[CTRL_XF1];
    end

endmodule

`default_nettype wire

/* File: tc_pkg.sv */
// Constants, register map and mode encoding for the dual timer/counter block.
// Assumes a 250 MHz system clock and register access over an AXI4-Lite slave.
//
// Behaviour
// - Timer function counts once per twelve system clocks when speed-up is clear.
// - Speed-up bit set makes the timer count on every system clock.
// - Counter function counts falling edges on the timer's count pin.
// - Count pin sampled once per timer-rate cycle; high then low registers a count.
// - Detected edge shows in the count at the end of the next rate cycle.
// - 13-bit mode sets the overflow flag on wrap from all ones; same both timers.
// - 16-bit mode is 13-bit mode using all sixteen count bits.
// - Auto-reload: low byte counts, overflow sets flag, reloads low from high byte.
// - Timer 1 in mode 3 stops and holds its count.
// - Timer 0 mode 3 splits; high byte times with Timer 1 run and flag.
// - Mode register: Timer 1 upper nibble, Timer 0 lower; gate, select, mode.
// - Mode field 00 13-bit, 01 16-bit, 10 auto-reload, 11 split or stop.
// - Select clear counts internal clock; set counts count-pin events.
// - Counting needs run bit, and with gate set also interrupt pin high.
// - Overflow flags set by hardware, cleared on vectoring, writable by software.
// - Run bits start and stop their timer under software control.
// - Interrupt type bit: clear selects low level, set selects falling edge.
// - Interrupt flag set on condition; edge-mode flag cleared when processed.
// - Speed-up selects for Timer 0 and 1 sit at bits 7 and 6 of auxiliary register.

package tc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMER_CTRL_FLAGS = 8'h88;
    localparam logic [7:0] IDX_TIMER_MODE_SELECT = 8'h89;
    localparam logic [7:0] IDX_TIMER0_COUNT_LOW = 8'h8a;
    localparam logic [7:0] IDX_TIMER1_COUNT_LOW = 8'h8b;
    localparam logic [7:0] IDX_TIMER0_COUNT_HIGH = 8'h8c;
    localparam logic [7:0] IDX_TIMER1_COUNT_HIGH = 8'h8d;
    localparam logic [7:0] IDX_AUX_CONTROL_2 = 8'ha6;

    localparam logic [7:0] REG_RESET = 8'h00;

    // Control/flag register bits
    localparam int CTRL_TF1 = 7;
    localparam int CTRL_TR1 = 6;
    localparam int CTRL_TF0 = 5;
    localparam int CTRL_TR0 = 4;
    localparam int CTRL_XF1 = 3;
    localparam int CTRL_XT1 = 2;
    localparam int CTRL_XF0 = 1;
    localparam int CTRL_XT0 = 0;

    // Mode register: one nibble per timer
    localparam int MODE_NIB_W = 4;
    localparam int NIB_GATE = 3;
    localparam int NIB_SELECT = 2;
    localparam int NIB_MODE_LSB = 0;

    // Auxiliary register speed-up bits, Timer 0 then Timer 1
    localparam int AUX_FAST0 = 7;
    localparam int AUX_FAST1 = 6;
    localparam logic [7:0] AUX_MASK = 8'hc0;

    // System clocks per standard machine cycle
    localparam int unsigned MACHINE_CYCLE_CLKS = 12;

    localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
    localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        TC_MODE_13,
        TC_MODE_16,
        TC_MODE_AUTO8,
        TC_MODE_SPLIT
    } tc_mode_t;

endpackage

/* File: tc_event_unit.sv */
// Count-event qualifier for one timer: timer rate or count-pin edges.
// Assumes the count pin is synchronous to sys_clk.

`timescale 1ns/1ps
`default_nettype none

module tc_event_unit (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic rate_tick,
    input wire logic count_ext,
    input wire logic enable,
    input wire logic count_pin,
    output logic inc
);

    logic sample_reg;
    logic pend_reg;

    // One sample per rate cycle; reset low so no false edge after release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sample_reg <= 1'b0;
        end else if (ce && rate_tick) begin
            sample_reg <= count_pin;
        end
    end

    // Edge seen this rate cycle is counted at the end of the next one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend_reg <= 1'b0;
        end else if (ce && rate_tick) begin
            pend_reg <= sample_reg & ~count_pin;
        end
    end

    always_comb begin
        inc = rate_tick & enable & (count_ext ? pend_reg : 1'b1);
    end

endmodule

`default_nettype wire

/* File: tc_assertions.sv */
// Checks on bus answers and flag outputs.
// Bound to tc_timer_top below; sees its ports only.

`timescale 1ns/1ps
`default_nettype none

module tc_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic ext_irq0_pin,
    input wire logic vec_ack_timer0,
    input wire logic vec_ack_timer1,
    input wire logic timer0_overflow_flag,
    input wire logic timer1_overflow_flag,
    input wire logic ext_irq0_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce |-> ##2 s_axi_bvalid)
        else $error("no write answer");
    chk_write_ready_low: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("ready while busy");
    chk_write_resp_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("response dropped");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid && !s_axi_arready)
        else $error("no read answer");
    chk_read_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper bits set");
    // Fall needs an ack or a write
    chk_tf0_clear_cause: assert property (
        $fell(timer0_overflow_flag) |-> $past(vec_ack_timer0) || $rose(s_axi_bvalid))
        else $error("tf0 clear uncaused");
    chk_tf1_clear_cause: assert property (
        $fell(timer1_overflow_flag) |-> $past(vec_ack_timer1) || $rose(s_axi_bvalid))
        else $error("tf1 clear uncaused");
    chk_ext0_set_cause: assert property (
        $rose(ext_irq0_flag) && !$rose(s_axi_bvalid) |-> !$past(ext_irq0_pin) || !$past(ext_irq0_pin, 2))
        else $error("ext0 set uncaused");
endmodule

bind tc_timer_top tc_assertions chk_u (
    .sys_clk, .rst, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .ext_irq0_pin, .vec_ack_timer0, .vec_ack_timer1, .timer0_overflow_flag,
    .timer1_overflow_flag, .ext_irq0_flag
);

`default_nettype wire

/* File: tc_pin_model.sv */
// Far-side model: count pins and external interrupt pins.
// Assumes the bench requests edges and gate levels on sys_clk.

`timescale 1ns/1ps
`default_nettype none

module tc_pin_model #(
    parameter int LOW_CYC = 30
) (
    input wire logic sys_clk,
    input wire logic [1:0] pulse_req,
    input wire logic [1:0] irq_level,
    output logic count_pin_0,
    output logic count_pin_1,
    output logic ext_irq0_pin,
    output logic ext_irq1_pin
);
    int cnt[2] = '{0, 0};

    // Idle high; low across two slow samples
    assign count_pin_0 = (cnt[0] == 0);
    assign count_pin_1 = (cnt[1] == 0);
    // Gate levels as commanded
    assign ext_irq0_pin = irq_level[0];
    assign ext_irq1_pin = irq_level[1];

    always @(posedge sys_clk) begin
        foreach (cnt[i]) begin
            if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
            else if (pulse_req[i]) cnt[i] <= LOW_CYC;
        end
    end
endmodule

`default_nettype wire

/* File: dual_timer_counter_t0_t1_tb.sv */
// Self-checking bench for tc_timer_top.
// Assumes tc_pin_model and the bound checker.

`timescale 1ns/1ps
`default_nettype none

module dual_timer_counter_t0_t1_tb;
    import tc_pkg::*;

    logic sys_clk = 0;
    logic rst = 1;
    logic [11:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, arvalid = 0;
    logic [31:0] wdata = 0;
    logic [3:0] ack = 0;
    logic [1:0] pulse_req = 0, irq_level = 2'h3, last_bresp;
    wire logic awready, wready, bvalid, arready, rvalid, cp0, cp1, ip0, ip1, tf0, tf1, xf0, xf1;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [7:0] regs[4] = '{IDX_TIMER_CTRL_FLAGS, IDX_TIMER_MODE_SELECT, IDX_TIMER0_COUNT_LOW, IDX_TIMER0_COUNT_HIGH};
    logic [7:0] m_hi[4] = '{8'hff, 8'hff, 8'h5a, 8'h00};
    logic [7:0] e_lo[4] = '{8'he0, 8'h00, 8'h5a, 8'h00};

    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;

    tc_timer_top dut_u (
        .sys_clk, .rst, .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .count_pin_0(cp0), .count_pin_1(cp1),
        .ext_irq0_pin(ip0), .ext_irq1_pin(ip1), .vec_ack_timer0(ack[0]), .vec_ack_timer1(ack[1]),
        .vec_ack_ext0(ack[2]), .vec_ack_ext1(ack[3]), .timer0_overflow_flag(tf0),
        .timer1_overflow_flag(tf1), .ext_irq0_flag(xf0), .ext_irq1_flag(xf1)
    );

    tc_pin_model pins_u (
        .sys_clk, .pulse_req, .irq_level, .count_pin_0(cp0), .count_pin_1(cp1),
        .ext_irq0_pin(ip0), .ext_irq1_pin(ip1)
    );

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic a;
        logic w;
        a = 1;
        w = 1;
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h00_0000, d};
        awvalid <= 1;
        wvalid <= 1;
        while (a || w) begin
            @(posedge sys_clk);
            if (a && awready) begin
                a = 0;
                awvalid <= 0;
            end
            if (w && wready) begin
                w = 0;
                wvalid <= 0;
            end
        end
        do @(posedge sys_clk); while (!bvalid);
        last_bresp = bresp;
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1;
        do @(posedge sys_clk); while (!arready);
        arvalid <= 0;
        do @(posedge sys_clk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask

    task automatic cr(input string what, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        chk(what, exp, d);
    endtask

    task automatic wait_flag(input int sel);
        int n;
        n = 0;
        while (!(sel != 0 ? tf1 : tf0) && n < 60) begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #60000;
        num_errors++;
        $display("unexpected run: expected done, seen timeout");
        finish_test();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int t1;
        repeat (20) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        foreach (regs[i]) cr("reset value", regs[i], 0);
        rd(8'h00, d, r);
        chk("rd resp", AXI_RESP_SLVERR, r);
        wr(8'h00, 8'hff);
        chk("wr resp", AXI_RESP_SLVERR, last_bresp);
        wr(IDX_AUX_CONTROL_2, 8'hff);
        cr("aux readback", IDX_AUX_CONTROL_2, AUX_MASK);
        wr(IDX_AUX_CONTROL_2, 8'h00);
        // One overflow per mode, stopped before the next slow tick
        for (int m = 0; m < 4; m++) begin
            wr(IDX_TIMER0_COUNT_LOW, 8'hff);
            wr(IDX_TIMER0_COUNT_HIGH, m_hi[m]);
            wr(IDX_TIMER_MODE_SELECT, 8'(m));
            wr(IDX_TIMER_CTRL_FLAGS, 8'h10);
            wait_flag(0);
            chk("mode flag", 1, tf0);
            wr(IDX_TIMER_CTRL_FLAGS, 8'h20);
            cr("low wrap", IDX_TIMER0_COUNT_LOW, e_lo[m]);
            cr("high wrap", IDX_TIMER0_COUNT_HIGH, e_lo[m] == 8'h5a ? 8'h5a : 8'h00);
            wr(IDX_TIMER_CTRL_FLAGS, 8'h00);
            chk("sw clear", 0, tf0);
        end
        // Auto-reload period, slow then fast rate
        for (int k = 0; k < 2; k++) begin
            wr(IDX_AUX_CONTROL_2, k != 0 ? 8'hc0 : 8'h00);
            wr(IDX_TIMER0_COUNT_HIGH, k != 0 ? 8'hf0 : 8'hff);
            wr(IDX_TIMER0_COUNT_LOW, k != 0 ? 8'hf0 : 8'hff);
            wr(IDX_TIMER_MODE_SELECT, 8'h02);
            wr(IDX_TIMER_CTRL_FLAGS, 8'h10);
            wait_flag(0);
            t1 = cyc;
            ack[0] <= 1;
            @(posedge sys_clk);
            ack[0] <= 0;
            @(posedge sys_clk);
            chk("ack clear", 0, tf0);
            wait_flag(0);
            chk("period", k != 0 ? 16 : MACHINE_CYCLE_CLKS, cyc - t1);
            wr(IDX_TIMER_CTRL_FLAGS, 8'h00);
        end
        wr(IDX_TIMER1_COUNT_LOW, 8'hff);
        wr(IDX_TIMER0_COUNT_HIGH, 8'hff);
        wr(IDX_TIMER_MODE_SELECT, 8'h33);
        wr(IDX_TIMER_CTRL_FLAGS, 8'h40);
        wait_flag(1);
        chk("split tf1", 1, tf1);
        chk("split tf0", 0, tf0);
        cr("timer1 held", IDX_TIMER1_COUNT_LOW, 8'hff);
        wr(IDX_TIMER_CTRL_FLAGS, 8'h00);
        // Counter function, both pins
        wr(IDX_AUX_CONTROL_2, 8'h00);
        wr(IDX_TIMER0_COUNT_LOW, 8'h00);
        wr(IDX_TIMER1_COUNT_LOW, 8'h00);
        wr(IDX_TIMER_MODE_SELECT, 8'h55);
        wr(IDX_TIMER_CTRL_FLAGS, 8'h50);
        repeat (3) begin
            pulse_req <= 2'h3;
            @(posedge sys_clk);
            pulse_req <= 2'h0;
            repeat (70) @(posedge sys_clk);
        end
        wr(IDX_TIMER_CTRL_FLAGS, 8'h00);
        cr("t0 events", IDX_TIMER0_COUNT_LOW, 3);
        cr("t1 events", IDX_TIMER1_COUNT_LOW, 3);
        // Gate, then both interrupt types
        wr(IDX_AUX_CONTROL_2, 8'h80);
        wr(IDX_TIMER0_COUNT_LOW, 8'h00);
        wr(IDX_TIMER_MODE_SELECT, 8'h09);
        irq_level <= 2'h2;
        wr(IDX_TIMER_CTRL_FLAGS, 8'h10);
        repeat (20) @(posedge sys_clk);
        chk("level low", 1, xf0);
        cr("gated count", IDX_TIMER0_COUNT_LOW, 0);
        irq_level <= 2'h3;
        repeat (20) @(posedge sys_clk);
        chk("level high", 0, xf0);
        rd(IDX_TIMER0_COUNT_LOW, d, r);
        chk("ungated", 1, d != 0);
        wr(IDX_TIMER_CTRL_FLAGS, 8'h01);
        irq_level <= 2'h2;
        repeat (3) @(posedge sys_clk);
        chk("edge set", 1, xf0);
        ack[2] <= 1;
        @(posedge sys_clk);
        ack[2] <= 0;
        @(posedge sys_clk);
        chk("edge ack", 0, xf0);
        chk("ext1 flag idle", 0, xf1);
        irq_level <= 2'h3;
        finish_test();
    end
endmodule

`default_nettype wire
